// *** logic/ssr_pkg.sv ***
// Purpose: Constants shared by the supply supervisor reset block.
// Assumes: 200 MHz mclk, comparator results arrive as digital levels.
// Notes:   Hold and debounce lengths are shortened through parameters.
//
// Notes on behaviour
// [RULE_01] The second-supply fail output is low while that supply is below its threshold and high above it.
// [RULE_02] The second-supply fail output follows its comparator with no hold delay.
// [RULE_03] The early warning output is low while the main supply is below its threshold and high above it.
// [RULE_04] A low manual reset input asserts the reset output at once.
// [RULE_05] The low-active reset output is open drain and pulled low on low main supply or manual reset.
// [RULE_06] The high-active reset output is push-pull and driven high on the same causes.
// [RULE_07] After power-up the reset output stays asserted for one full hold period.
// [RULE_08] After manual reset is released the reset output stays asserted for one more full hold period.
// [RULE_09] The watchdog restarts on SDA falling while SCL is high, then SCL falling, followed by a stop condition.
// [RULE_10] With no restart pattern inside the time-out the watchdog output is asserted.
// [RULE_11] SDA is only ever driven low, and its input is always sampled.
// [RULE_12] The watchdog output is active low open drain while the watchdog is expired.
// [RULE_13] The early warning asserts ahead of reset and has no power-up hold.
// [RULE_14] The hold period restarts on any reset cause and releases only after an uninterrupted count.
// [RULE_15] Comparators and manual reset are synchronised, and manual reset is debounced.

package ssr_pkg;

	// Time figures in their own units, and the clock rate.
	localparam int unsigned CLK_MHZ         = 200;
	localparam int unsigned HOLD_MS         = 50;
	localparam int unsigned DEBOUNCE_US     = 100;
	localparam int unsigned WDOG_MS         = 25;

	// Cycle counts derived from the times above.
	localparam int unsigned HOLD_CYCLES     = HOLD_MS * 1000 * CLK_MHZ;
	localparam int unsigned DEBOUNCE_CYCLES = DEBOUNCE_US * CLK_MHZ;
	localparam int unsigned WDOG_CYCLES     = WDOG_MS * 1000 * CLK_MHZ;

	// Counter width wide enough for every count above.
	localparam int unsigned CNT_W           = 32;

	// Synchroniser depth.
	localparam int unsigned SYNC_STAGES     = 2;

	// Watchdog pattern states.
	typedef enum logic [1:0] {
		SSR_PAT_IDLE,
		SSR_PAT_ARMED,
		SSR_PAT_WAIT_STOP
	} ssr_pat_e;

endpackage : ssr_pkg

// *** logic/ssr_sync.sv ***
// Purpose: Two-flop synchroniser for one level input.
// Assumes: Single clock domain, synchronous active-high reset.
// Notes:   The first stage feeds only the second stage.

`timescale 1ns/1ps

module ssr_sync #(
	parameter logic RESET_VAL = 1'b1
) (
	// Clock and reset.
	input  wire logic mclk,
	input  wire logic rst,
	// Level in and synchronised level out.
	input  wire logic din,
	output logic      dout
);

	logic stage1;
	logic next_stage1;
	logic next_dout;

	// Shift the level through two flops.
	always_comb begin
		next_stage1 = din;
		next_dout   = stage1;
	end

	// Register the stages; reset loads a constant only.
	always_ff @(posedge mclk) begin
		if (rst) begin
			stage1 <= RESET_VAL;
			dout   <= RESET_VAL;
		end else begin
			stage1 <= next_stage1;
			dout   <= next_dout;
		end
	end

endmodule : ssr_sync

// *** logic/ssr_supervisor.sv ***
// Purpose: Reset, supply fail, early warning and watchdog outputs.
// Assumes: Comparator inputs are high while the supply is above threshold.
// Notes:   Both reset polarities are produced; the board picks one.

`timescale 1ns/1ps

module ssr_supervisor #(
	parameter int unsigned HOLD_CYCLES     = ssr_pkg::HOLD_CYCLES,
	parameter int unsigned DEBOUNCE_CYCLES = ssr_pkg::DEBOUNCE_CYCLES,
	parameter int unsigned WDOG_CYCLES     = ssr_pkg::WDOG_CYCLES
) (
	// Clock and reset.
	input  wire logic mclk,
	input  wire logic rst,
	// Comparator results, high when above threshold.
	input  wire logic main_supply_ok,
	input  wire logic second_supply_sense,
	// Manual reset button, active low.
	input  wire logic manual_reset_n,
	// Serial lines; SDA as input, output and enable.
	input  wire logic scl_in,
	input  wire logic sda_in,
	output logic      sda_out,
	output logic      sda_oe,
	// Supply status outputs.
	output logic      second_supply_fail_n,
	output logic      early_low_supply_n,
	// Reset outputs: open drain low-active and push-pull high-active.
	output logic      reset_out,
	output logic      reset_oe,
	output logic      reset_active_high,
	// Watchdog output, open drain low-active.
	output logic      watchdog_out,
	output logic      watchdog_expired_oe
);

	////////////////////////////////////////////////////////////////////////
	// Input synchronisers.

	logic main_ok_s;
	logic second_ok_s;
	logic mr_n_s;
	logic scl_s;
	logic sda_s;

	// Reset values assume supplies low, so outputs start asserted.
	ssr_sync #(.RESET_VAL(1'b0)) u_sync_main (
		.mclk(mclk), .rst(rst), .din(main_supply_ok), .dout(main_ok_s)
	); // RULE_15
	ssr_sync #(.RESET_VAL(1'b0)) u_sync_second (
		.mclk(mclk), .rst(rst), .din(second_supply_sense),
		.dout(second_ok_s)
	); // RULE_15
	ssr_sync #(.RESET_VAL(1'b1)) u_sync_mr (
		.mclk(mclk), .rst(rst), .din(manual_reset_n), .dout(mr_n_s)
	); // RULE_15
	ssr_sync #(.RESET_VAL(1'b1)) u_sync_scl (
		.mclk(mclk), .rst(rst), .din(scl_in), .dout(scl_s)
	);
	// SDA receiver is never gated, even while the device pulls it.
	ssr_sync #(.RESET_VAL(1'b1)) u_sync_sda (
		.mclk(mclk), .rst(rst), .din(sda_in), .dout(sda_s)
	); // RULE_11

	////////////////////////////////////////////////////////////////////////
	// Manual reset debounce and reset hold.

	logic                      mr_db_n;
	logic                      next_mr_db_n;
	logic [ssr_pkg::CNT_W-1:0] db_cnt;
	logic [ssr_pkg::CNT_W-1:0] next_db_cnt;
	logic [ssr_pkg::CNT_W-1:0] hold_cnt;
	logic [ssr_pkg::CNT_W-1:0] next_hold_cnt;
	logic                      rst_active;
	logic                      next_rst_active;
	logic                      cause;

	// A press is taken at once; only the release is debounced, so
	// reset is never late but bounce cannot end the hold early.
	always_comb begin
		next_mr_db_n = mr_db_n;
		next_db_cnt  = '0;
		if (!mr_n_s) begin
			next_mr_db_n = 1'b0; // RULE_04
		end else if (!mr_db_n) begin
			if (db_cnt >= ssr_pkg::CNT_W'(DEBOUNCE_CYCLES - 1)) begin
				next_mr_db_n = 1'b1; // RULE_15
			end else begin
				next_db_cnt = db_cnt + 1'b1;
			end
		end
	end

	// Hold counter restarts on any cause and releases after a full run.
	assign cause = !main_ok_s || !mr_n_s || !mr_db_n;

	always_comb begin
		next_hold_cnt   = hold_cnt;
		next_rst_active = rst_active;
		if (cause) begin
			next_hold_cnt   = '0; // RULE_14
			next_rst_active = 1'b1; // RULE_04
		end else if (rst_active) begin
			if (hold_cnt >= ssr_pkg::CNT_W'(HOLD_CYCLES - 1)) begin
				next_rst_active = 1'b0; // RULE_07 RULE_08
			end else begin
				next_hold_cnt = hold_cnt + 1'b1; // RULE_14
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			mr_db_n    <= 1'b1;
			db_cnt     <= '0;
			hold_cnt   <= '0;
			rst_active <= 1'b1;
		end else begin
			mr_db_n    <= next_mr_db_n;
			db_cnt     <= next_db_cnt;
			hold_cnt   <= next_hold_cnt;
			rst_active <= next_rst_active;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Watchdog restart pattern and time-out.

	ssr_pkg::ssr_pat_e         pat;
	ssr_pkg::ssr_pat_e         next_pat;
	logic                      scl_q;
	logic                      sda_q;
	logic [ssr_pkg::CNT_W-1:0] wd_cnt;
	logic [ssr_pkg::CNT_W-1:0] next_wd_cnt;
	logic                      wd_expired;
	logic                      next_wd_expired;
	logic                      kick;
	logic                      sda_fall;
	logic                      sda_rise;
	logic                      scl_fall;

	assign sda_fall = sda_q && !sda_s;
	assign sda_rise = !sda_q && sda_s;
	assign scl_fall = scl_q && !scl_s;

	// SDA falls with SCL high, then SCL falls, then a stop (SDA rising
	// with SCL high) completes the kick.
	always_comb begin
		next_pat = pat;
		kick     = 1'b0;
		case (pat)
			ssr_pkg::SSR_PAT_IDLE: begin
				if (sda_fall && scl_s) begin
					next_pat = ssr_pkg::SSR_PAT_ARMED; // RULE_09
				end
			end
			ssr_pkg::SSR_PAT_ARMED: begin
				if (scl_fall) begin
					next_pat = ssr_pkg::SSR_PAT_WAIT_STOP; // RULE_09
				end else if (sda_rise) begin
					next_pat = ssr_pkg::SSR_PAT_IDLE;
				end
			end
			ssr_pkg::SSR_PAT_WAIT_STOP: begin
				if (sda_rise && scl_s) begin
					kick     = 1'b1; // RULE_09
					next_pat = ssr_pkg::SSR_PAT_IDLE;
				end
			end
			default: begin
				next_pat = ssr_pkg::SSR_PAT_IDLE;
			end
		endcase
	end

	// Time-out counter; a kick also clears an expired watchdog.
	always_comb begin
		next_wd_cnt     = wd_cnt;
		next_wd_expired = wd_expired;
		if (kick) begin
			next_wd_cnt     = '0;
			next_wd_expired = 1'b0;
		end else if (wd_cnt >= ssr_pkg::CNT_W'(WDOG_CYCLES - 1)) begin
			next_wd_expired = 1'b1; // RULE_10
		end else begin
			next_wd_cnt = wd_cnt + 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			pat        <= ssr_pkg::SSR_PAT_IDLE;
			scl_q      <= 1'b1;
			sda_q      <= 1'b1;
			wd_cnt     <= '0;
			wd_expired <= 1'b0;
		end else begin
			pat        <= next_pat;
			scl_q      <= scl_s;
			sda_q      <= sda_s;
			wd_cnt     <= next_wd_cnt;
			wd_expired <= next_wd_expired;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Output registers.

	logic next_second_fail_n;
	logic next_early_n;

	// Status outputs follow comparators with no hold. The reset outputs
	// take the hold state one register later, so the early warning leads
	// reset by a cycle; the cost is one more cycle of reset latency.
	always_comb begin
		next_second_fail_n = second_ok_s; // RULE_01 RULE_02
		next_early_n       = main_ok_s; // RULE_03 RULE_13
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			second_supply_fail_n <= 1'b0;
			early_low_supply_n   <= 1'b0;
			reset_out            <= 1'b0;
			reset_oe             <= 1'b1;
			reset_active_high    <= 1'b1;
			watchdog_out         <= 1'b0;
			watchdog_expired_oe  <= 1'b0;
			sda_out              <= 1'b0;
			sda_oe               <= 1'b0;
		end else begin
			second_supply_fail_n <= next_second_fail_n;
			early_low_supply_n   <= next_early_n;
			reset_out            <= 1'b0; // RULE_05
			reset_oe             <= rst_active; // RULE_05 RULE_13
			reset_active_high    <= rst_active; // RULE_06 RULE_13
			watchdog_out         <= 1'b0; // RULE_12
			watchdog_expired_oe  <= next_wd_expired; // RULE_12
			sda_out              <= 1'b0; // RULE_11
			sda_oe               <= 1'b0; // RULE_11
		end
	end

endmodule : ssr_supervisor

// *** verif/ssr_checker.sv ***
// Purpose: Port-level assertions for the supply supervisor.
// Assumes: Inputs hold each level for four cycles or more.
// Notes:   Bound to every ssr_supervisor instance.
`timescale 1ns/1ps
module ssr_checker #(
	parameter int unsigned HOLD_CYCLES     = 20,
	parameter int unsigned DEBOUNCE_CYCLES = 4,
	parameter int unsigned WDOG_CYCLES     = 50
) (
	// Clock, reset and inputs.
	input wire logic mclk,
	input wire logic rst,
	input wire logic main_supply_ok,
	input wire logic second_supply_sense,
	input wire logic manual_reset_n,
	input wire logic sda_in,
	// Outputs watched.
	input wire logic sda_out,
	input wire logic sda_oe,
	input wire logic second_supply_fail_n,
	input wire logic early_low_supply_n,
	input wire logic reset_out,
	input wire logic reset_oe,
	input wire logic reset_active_high,
	input wire logic watchdog_out,
	input wire logic watchdog_expired_oe
);
	int unsigned calm;
	int unsigned quiet;
	logic        sda_q;
	// Cycles free of any reset cause, and since SDA last moved.
	always_ff @(posedge mclk) begin
		calm  <= (rst || !main_supply_ok || !manual_reset_n) ? 0 : calm + 1;
		quiet <= (rst || sda_in != sda_q) ? 0 : quiet + 1;
		sda_q <= sda_in;
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	chk_fail_low: assert property (
		(!second_supply_sense)[*4] |=> !second_supply_fail_n)
		else $error("second fail output not low");
	chk_fail_high: assert property (
		second_supply_sense[*4] |=> second_supply_fail_n)
		else $error("second fail output not released");
	chk_early_follow: assert property (
		$stable(main_supply_ok)[*4]
		|=> early_low_supply_n == $past(main_supply_ok))
		else $error("early warning does not follow supply");
	chk_early_ahead: assert property (
		$rose(reset_oe) && $past(manual_reset_n, 4)
		|-> !$past(early_low_supply_n))
		else $error("reset rose without early warning");
	chk_reset_cause: assert property (
		(!main_supply_ok || !manual_reset_n)[*4] |=> reset_oe)
		else $error("reset not asserted on cause");
	chk_reset_pair: assert property (
		reset_active_high == reset_oe && !reset_out)
		else $error("reset polarities disagree");
	chk_hold_min: assert property (
		$fell(reset_oe) |-> calm >= HOLD_CYCLES)
		else $error("reset released before hold");
	chk_hold_max: assert property (
		calm == HOLD_CYCLES + DEBOUNCE_CYCLES + 8 |-> !reset_oe)
		else $error("reset held too long");
	chk_wdog_late: assert property (
		quiet == WDOG_CYCLES + 8 |-> watchdog_expired_oe)
		else $error("watchdog did not expire");
	chk_sda_open: assert property (
		!sda_oe && !sda_out && !watchdog_out)
		else $error("open drain output driven high");
endmodule : ssr_checker
bind ssr_supervisor ssr_checker #(.HOLD_CYCLES(HOLD_CYCLES),
	.DEBOUNCE_CYCLES(DEBOUNCE_CYCLES), .WDOG_CYCLES(WDOG_CYCLES))
	ssr_checker_inst (.mclk(mclk), .rst(rst), .sda_in(sda_in),
	.main_supply_ok(main_supply_ok), .manual_reset_n(manual_reset_n),
	.second_supply_sense(second_supply_sense), .sda_out(sda_out),
	.sda_oe(sda_oe), .second_supply_fail_n(second_supply_fail_n),
	.early_low_supply_n(early_low_supply_n), .reset_out(reset_out),
	.reset_oe(reset_oe), .reset_active_high(reset_active_high),
	.watchdog_out(watchdog_out), .watchdog_expired_oe(watchdog_expired_oe));

// *** verif/ssr_host_model.sv ***
// Purpose: Host side of the serial lines, with pull-ups.
// Assumes: kick is called just after a clock edge.
// Notes:   Each line edge lasts three cycles so the device sees it.
`timescale 1ns/1ps
module ssr_host_model (
	// Device drive of SDA.
	input  wire logic sda_out,
	input  wire logic sda_oe,
	// Line levels seen by the device.
	output logic      scl_in,
	output logic      sda_in
);
	logic scl;
	logic sda_low;
	// Pull-ups win unless a party pulls low; wired-AND line.
	assign scl_in = scl;
	assign sda_in = !(sda_low || (sda_oe && !sda_out));
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	// Service pattern; abort lets SDA rise before SCL falls.
	task automatic kick(input bit abort);
		sda_low = 1'b1;
		#15;
		if (!abort) begin
			scl = 1'b0;
			#15;
			scl = 1'b1;
			#15;
		end
		sda_low = 1'b0;
		#15;
	endtask : kick
endmodule : ssr_host_model

// *** verif/supply_supervisor_reset_outputs_tb.sv ***
// Purpose: Self-checking bench for ssr_supervisor.
// Assumes: Short counts set through parameters.
// Notes:   Inputs change 1 ns after the rising edge.
`timescale 1ns/1ps
module supply_supervisor_reset_outputs_tb;
	localparam int unsigned HOLD = 20;
	localparam int unsigned DEB  = 4;
	localparam int unsigned WDOG = 50;
	logic mclk, rst, main_ok, sense, man_n, scl, sda, sda_out, sda_oe;
	logic fail_n, early_n, r_out, r_oe, r_hi, wd_out, wd_oe;
	int   err_count, n_compared, n;
	int   seed = 19;
	bit   exp_q[$];
	ssr_supervisor #(.HOLD_CYCLES(HOLD), .DEBOUNCE_CYCLES(DEB),
		.WDOG_CYCLES(WDOG)) ssr_supervisor_inst (.mclk(mclk), .rst(rst),
		.main_supply_ok(main_ok), .second_supply_sense(sense),
		.manual_reset_n(man_n), .scl_in(scl), .sda_in(sda),
		.sda_out(sda_out), .sda_oe(sda_oe), .second_supply_fail_n(fail_n),
		.early_low_supply_n(early_n), .reset_out(r_out), .reset_oe(r_oe),
		.reset_active_high(r_hi), .watchdog_out(wd_out),
		.watchdog_expired_oe(wd_oe));
	ssr_host_model ssr_host_model_inst (.sda_out(sda_out),
		.sda_oe(sda_oe), .scl_in(scl), .sda_in(sda));
	task automatic check(input string what, input logic seen, exp);
		n_compared++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED %s expected %b seen %b", what, exp, seen);
		end
	endtask : check
	task automatic step(input int k);
		repeat (k) @(posedge mclk);
		#1;
	endtask : step
	// Cycles until the reset output releases, bounded.
	task automatic release_time(output int c);
		c = 0;
		while (r_oe === 1'b1 && c < 200) begin
			step(1);
			c++;
		end
	endtask : release_time
	task automatic stop_test;
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : stop_test
	// Free-running 200 MHz clock.
	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	// Watchdog on the run; a few thousand cycles is ample.
	initial begin
		#20000;
		err_count++;
		stop_test();
	end
	// Main sequence.
	initial begin
		{rst, main_ok, sense, man_n} = 4'hf;
		step(10);
		rst = 1'b0;
		release_time(n);
		check("powerup hold", n >= HOLD && n <= HOLD + 8, 1'b1);
		for (int i = 0; i < 16; i++) begin
			sense = 1'($random(seed));
			exp_q.push_back(sense);
			step(4);
			check("second fail", fail_n, exp_q.pop_front());
		end
		main_ok = 1'b0;
		step(3);
		// The warning must already stand while reset has not yet risen.
		check("early ahead", early_n, 1'b0);
		check("reset not yet", r_oe, 1'b0);
		step(1);
		check("early low", early_n, 1'b0);
		check("reset low active", r_oe, 1'b1);
		check("reset high active", r_hi, 1'b1);
		main_ok = 1'b1;
		step(4);
		check("early high", early_n, 1'b1);
		check("reset still held", r_oe, 1'b1);
		release_time(n);
		check("brownout hold", n + 4 >= HOLD && n <= HOLD + 4, 1'b1);
		man_n = 1'b0;
		step(6);
		check("manual reset", r_hi, 1'b1);
		man_n = 1'b1;
		step(HOLD - 4);
		man_n = 1'b0;
		step(6);
		man_n = 1'b1;
		release_time(n);
		// Unsigned difference: a hold shorter than HOLD + DEB wraps and fails.
		check("manual hold", (n - HOLD - DEB) <= 8, 1'b1);
		step(WDOG + 4);
		check("watchdog expired", wd_oe, 1'b1);
		ssr_host_model_inst.kick(1'b1);
		step(2);
		check("aborted kick", wd_oe, 1'b1);
		ssr_host_model_inst.kick(1'b0);
		step(3);
		check("kick clears", wd_oe, 1'b0);
		step(WDOG - 12);
		check("still serviced", wd_oe, 1'b0);
		step(20);
		check("expires again", wd_oe, 1'b1);
		check("sda never driven", sda_oe, 1'b0);
		// Mid-run reset: outputs take reset values, then a full hold again.
		rst = 1'b1;
		step(3);
		check("reset in reset", r_oe, 1'b1);
		check("watchdog in reset", wd_oe, 1'b0);
		rst = 1'b0;
		release_time(n);
		check("rerun hold", n >= HOLD && n <= HOLD + 8, 1'b1);
		stop_test();
	end
endmodule : supply_supervisor_reset_outputs_tb
